// [src/gem_edge_mask.sv]
// Purpose: Falling and rising edge-enable masks for the general pins,
//          with the pin input view and the edge latch they feed.
// Assumes: Pins and register strobes are synchronous to ref_clk.
// Notes:   Read data is registered; answer one cycle after rd_en.
//
// Function
// - Falling-edge enable mask at 1Ch set, 1Dh clear
// - Rising-edge enable mask at 1Eh set, 1Fh clear
// - Either location reads the stored mask value
// - Set-location ones become one
// - Clear-location ones become zero
// - Zero bits written leave stored bits unchanged
// - Eight bits each, pins on bits 0-2
// - Enabled edge sets latch bit; ones clear
// - Read-only input register shows sampled pin levels
`timescale 1ns/1ps
`include "gem_map.svh"
module gem_edge_mask (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire gem_pkg::gem_pins_t pin_in,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire gem_pkg::gem_addr_t addr,
  input wire gem_pkg::gem_byte_t wdata,
  output gem_pkg::gem_byte_t rdata,
  output gem_pkg::gem_pins_t fall_enable,
  output gem_pkg::gem_pins_t rise_enable,
  output gem_pkg::gem_pins_t edge_event,
  output gem_pkg::gem_byte_t latch_value
);
  import gem_pkg::*;

  gem_byte_t fall_val;
  gem_byte_t rise_val;
  gem_byte_t rdata_q;
  gem_byte_t rdata_d;
  gem_byte_t latch_q;
  gem_byte_t latch_d;
  gem_pins_t pin_s1_q;
  gem_pins_t pin_s2_q;
  gem_pins_t pin_prev_q;
  gem_pins_t fall_en_q;
  gem_pins_t rise_en_q;
  gem_pins_t event_q;
  gem_pins_t event_d;
  logic fall_set;
  logic fall_clr;
  logic rise_set;
  logic rise_clr;

  function automatic logic hit(input gem_addr_t a, input gem_addr_t loc);
    hit = (a == loc);
  endfunction : hit

  assign fall_set = wr_en && hit(addr, `GEM_ADDR_FALL_SET);
  assign fall_clr = wr_en && hit(addr, `GEM_ADDR_FALL_CLR);
  assign rise_set = wr_en && hit(addr, `GEM_ADDR_RISE_SET);
  assign rise_clr = wr_en && hit(addr, `GEM_ADDR_RISE_CLR);

  // Falling-edge mask, full eight bits of storage
  gem_mask_reg u_fall (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .set_stb(fall_set),
    .clr_stb(fall_clr),
    .wdata(wdata),
    .value(fall_val)
  );

  gem_mask_reg u_rise (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .set_stb(rise_set),
    .clr_stb(rise_clr),
    .wdata(wdata),
    .value(rise_val)
  );

  // Two-stage sync; first stage feeds only the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
      pin_prev_q <= 3'h0;
    end else begin
      pin_s1_q <= pin_in;
      pin_s2_q <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  always_comb begin
    event_d = (pin_prev_q & ~pin_s2_q & fall_val[2:0])
            | (~pin_prev_q & pin_s2_q & rise_val[2:0]);
  end

  // Event set wins over a same-cycle clear so no edge is lost
  always_comb begin
    latch_d = latch_q;
    if (wr_en && hit(addr, `GEM_ADDR_LATCH_CLR)) begin
      latch_d = latch_d & ~wdata;
    end
    if (wr_en && hit(addr, `GEM_ADDR_LATCH_SET)) begin
      latch_d = latch_d | wdata;
    end
    latch_d[2:0] = latch_d[2:0] | event_d;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= `GEM_LATCH_RESET;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_comb begin
    case (addr)
      `GEM_ADDR_INPUT: rdata_d = {5'h0_0, pin_s2_q};
      `GEM_ADDR_LATCH_SET, `GEM_ADDR_LATCH_CLR: rdata_d = latch_q;
      `GEM_ADDR_FALL_SET, `GEM_ADDR_FALL_CLR: rdata_d = fall_val;
      `GEM_ADDR_RISE_SET, `GEM_ADDR_RISE_CLR: rdata_d = rise_val;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else if (rd_en) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      fall_en_q <= 3'h0;
      rise_en_q <= 3'h0;
      event_q <= 3'h0;
    end else begin
      fall_en_q <= fall_val[2:0];
      rise_en_q <= rise_val[2:0];
      event_q <= event_d;
    end
  end

  assign rdata = rdata_q;
  assign fall_enable = fall_en_q;
  assign rise_enable = rise_en_q;
  assign edge_event = event_q;
  assign latch_value = latch_q;

  chk_read_fall: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_en && (addr == `GEM_ADDR_FALL_SET || addr == `GEM_ADDR_FALL_CLR)
      |=> rdata == $past(fall_val))
    else $error("Falling mask read mismatch");
  chk_read_rise: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_en && (addr == `GEM_ADDR_RISE_SET || addr == `GEM_ADDR_RISE_CLR)
      |=> rdata == $past(rise_val))
    else $error("Rising mask read mismatch");
  chk_fall_latch: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (fall_val[0] && pin_prev_q[0] && !pin_s2_q[0]) |=> latch_q[0])
    else $error("Enabled falling edge not latched");
  chk_rise_latch: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (rise_val[1] && !pin_prev_q[1] && pin_s2_q[1]) |=> latch_q[1])
    else $error("Enabled rising edge not latched");
  chk_no_event: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (fall_val[2:0] == 3'h0 && rise_val[2:0] == 3'h0) |=> event_q == 3'h0)
    else $error("Event without enable");
  chk_input_view: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == `GEM_ADDR_INPUT |=> rdata[7:3] == 5'h0_0)
    else $error("Input register upper bits not zero");
  chk_mask_width: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fall_set && wdata == 8'hFF |=> fall_val == 8'hFF)
    else $error("Mask storage not eight bits");
  chk_latch_clear: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == `GEM_ADDR_LATCH_CLR && event_d == 3'h0
      |=> (latch_q & $past(wdata)) == 8'h00)
    else $error("Latch clear failed");

  // Register views and pin-side outputs
  chk_latch_read: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_en && (addr == `GEM_ADDR_LATCH_SET || addr == `GEM_ADDR_LATCH_CLR)
      |=> rdata == $past(latch_q))
    else $error("Latch read mismatch");
  chk_input_read: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rd_en && addr == `GEM_ADDR_INPUT |=> rdata[2:0] == $past(pin_s2_q))
    else $error("Input register does not show pin levels");
  chk_input_ro: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wr_en && addr == `GEM_ADDR_INPUT
      |=> $stable(fall_val) && $stable(rise_val))
    else $error("Write to input register changed a mask");
  chk_rdata_hold: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !rd_en |=> $stable(rdata))
    else $error("Read data changed without a read");
  chk_fall_pins: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    fall_enable == $past(fall_val[2:0]))
    else $error("Falling enable outputs do not follow the mask");
  chk_rise_pins: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    rise_enable == $past(rise_val[2:0]))
    else $error("Rising enable outputs do not follow the mask");
  chk_event_pulse: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    edge_event == $past(event_d))
    else $error("Edge event is not a one-cycle copy");
  chk_event_wins: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    event_d != 3'h0 |=> (latch_q[2:0] & $past(event_d)) == $past(event_d))
    else $error("Edge lost to a latch clear");
endmodule : gem_edge_mask

// [src/gem_map.svh]
// Purpose: Register offsets, field positions and reset values for the
//          pin edge-enable block.
// Assumes: 8-bit register map reached through the serial controller.
// Notes:   Definitions only.
`ifndef GEM_MAP_SVH
`define GEM_MAP_SVH

`define GEM_ADDR_INPUT      8'h18
`define GEM_ADDR_LATCH_SET  8'h1A
`define GEM_ADDR_LATCH_CLR  8'h1B
`define GEM_ADDR_FALL_SET   8'h1C
`define GEM_ADDR_FALL_CLR   8'h1D
`define GEM_ADDR_RISE_SET   8'h1E
`define GEM_ADDR_RISE_CLR   8'h1F
`define GEM_MASK_RESET      8'h00
`define GEM_LATCH_RESET     8'h00
`define GEM_PIN_COUNT       3
`define GEM_PIN_LO          0
`define GEM_PIN_HI          2

`endif

// [src/gem_pkg.sv]
// Purpose: Types shared by the pin edge-enable block.
// Assumes: Constants live in gem_map.svh.
// Notes:   Types only.
package gem_pkg;
  typedef logic [7:0] gem_byte_t;
  typedef logic [7:0] gem_addr_t;
  typedef logic [2:0] gem_pins_t;
endpackage : gem_pkg

// [src/gem_mask_reg.sv]
// Purpose: One 8-bit register with set and clear write locations.
// Assumes: One write strobe per cycle; set and clear never together.
// Notes:   Value comes straight from the flip-flops.
`timescale 1ns/1ps
`include "gem_map.svh"
module gem_mask_reg (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic set_stb,
  input wire logic clr_stb,
  input wire gem_pkg::gem_byte_t wdata,
  output gem_pkg::gem_byte_t value
);
  import gem_pkg::*;

  gem_byte_t val_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      val_q <= `GEM_MASK_RESET;
    end else if (set_stb) begin
      val_q <= val_q | wdata;
    end else if (clr_stb) begin
      val_q <= val_q & ~wdata;
    end
  end

  assign value = val_q;

  chk_set_ones: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    set_stb |=> ((val_q & $past(wdata)) == $past(wdata)))
    else $error("Set write did not raise its bits");
  chk_clr_ones: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    clr_stb && !set_stb |=> ((val_q & $past(wdata)) == 8'h00))
    else $error("Clear write did not drop its bits");
  chk_zero_keep: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (set_stb || clr_stb)
      |=> ((val_q & ~$past(wdata)) == ($past(val_q) & ~$past(wdata))))
    else $error("Bits written as zero changed");
endmodule : gem_mask_reg

// [tb/gem_edge_mask_tb_top.sv]
// Purpose: Self-checking bench for the pin edge-enable block.
// Assumes: One-cycle strobes, read data one cycle after rd_en.
// Notes:   Fixed-seed random mask traffic plus hand corner cases.
`timescale 1ns/1ps
`include "gem_map.svh"
module gem_edge_mask_tb_top;
  import gem_pkg::*;
  logic ref_clk, resetn, wr_en, rd_en;
  gem_pins_t pin_in, fall_enable, rise_enable, edge_event, ev;
  gem_addr_t addr, a;
  gem_byte_t wdata, rdata, latch_value, fm, rm, got, d;
  int errors, n_compared, cycles, seed, i;
  gem_addr_t ca[5] = '{8'h1C, 8'h1D, 8'h1D, 8'h1C, 8'h1E};
  gem_byte_t cd[5] = '{8'hFF, 8'h00, 8'h5A, 8'h00, 8'h88};
  gem_edge_mask dut (.ref_clk(ref_clk), .resetn(resetn), .pin_in(pin_in),
    .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
    .rdata(rdata), .fall_enable(fall_enable), .rise_enable(rise_enable),
    .edge_event(edge_event), .latch_value(latch_value));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string what, input gem_byte_t exp,
                     input gem_byte_t seen);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input gem_addr_t wa, input gem_byte_t wd);
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= wa;
    wdata <= wd;
    @(posedge ref_clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input gem_addr_t ra);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= ra;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1 got = rdata;
  endtask : rd
  // Ones set at even offset, ones clear at odd, zeros keep
  function automatic gem_byte_t upd(gem_byte_t cur, gem_addr_t wa,
                                    gem_byte_t wd);
    return wa[0] ? (cur & ~wd) : (cur | wd);
  endfunction : upd
  task automatic edge_wait;
    ev = 3'h0;
    repeat (6) begin
      @(posedge ref_clk);
      #1 ev = ev | edge_event;
    end
  endtask : edge_wait
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    resetn = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    pin_in = 3'h0;
    addr = 8'h00;
    wdata = 8'h00;
    fm = `GEM_MASK_RESET;
    rm = `GEM_MASK_RESET;
    seed = 97328;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    chk("latch reset", `GEM_LATCH_RESET, latch_value);
    rd(`GEM_ADDR_FALL_SET);
    chk("fall reset", `GEM_MASK_RESET, got);
    rd(`GEM_ADDR_RISE_CLR);
    chk("rise reset", `GEM_MASK_RESET, got);
    for (i = 0; i < 45; i++) begin
      a = (i < 5) ? ca[i] : 8'h1C + 8'($random(seed) & 3);
      d = (i < 5) ? cd[i] : 8'($random(seed));
      wr(a, d);
      if (a[1]) rm = upd(rm, a, d);
      else fm = upd(fm, a, d);
      rd(8'h1C + 8'($random(seed) & 1));
      chk("fall mask", fm, got);
      rd(8'h1E + 8'($random(seed) & 1));
      chk("rise mask", rm, got);
      chk("fall pins", {5'h0, fm[2:0]}, {5'h0, fall_enable});
      chk("rise pins", {5'h0, rm[2:0]}, {5'h0, rise_enable});
    end
    wr(`GEM_ADDR_INPUT, 8'hFF);
    wr(8'h30, 8'hFF);
    rd(8'h30);
    chk("unmapped read", 8'h00, got);
    rd(`GEM_ADDR_FALL_CLR);
    chk("fall kept", fm, got);
    wr(`GEM_ADDR_FALL_CLR, 8'hFF);
    wr(`GEM_ADDR_RISE_CLR, 8'hFF);
    wr(`GEM_ADDR_FALL_SET, 8'h05);
    wr(`GEM_ADDR_RISE_SET, 8'h06);
    wr(`GEM_ADDR_LATCH_CLR, 8'hFF);
    @(posedge ref_clk);
    pin_in <= 3'h7;
    edge_wait();
    chk("rise latch", 8'h06, latch_value);
    chk("rise event", 8'h06, {5'h0, ev});
    rd(`GEM_ADDR_INPUT);
    chk("pin input", 8'h07, got);
    wr(`GEM_ADDR_LATCH_CLR, 8'hFF);
    #1;
    chk("latch clear", 8'h00, latch_value);
    @(posedge ref_clk);
    pin_in <= 3'h0;
    edge_wait();
    chk("fall latch", 8'h05, latch_value);
    chk("fall event", 8'h05, {5'h0, ev});
    rd(`GEM_ADDR_LATCH_SET);
    chk("latch read", 8'h05, got);
    wr(`GEM_ADDR_LATCH_SET, 8'hA0);
    #1;
    chk("latch soft set", 8'hA5, latch_value);
    tally_and_finish();
  end
endmodule : gem_edge_mask_tb_top
